/* rtl/pwr_ret_pkg.sv */
// Package for the power and retention register bank.
// Assumes a single 250 MHz system clock and 32-bit Avalon-MM access.
package pwr_ret_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_SUPPLY_WARNING = 12'h510;
    localparam logic [11:0] OFF_SCRATCH_A      = 12'h51c;
    localparam logic [11:0] OFF_SCRATCH_B      = 12'h520;
    localparam logic [11:0] OFF_REG_ENABLE     = 12'h578;
    localparam logic [11:0] OFF_RAM_CTRL_BASE  = 12'h900;
    localparam logic [11:0] OFF_RAM_SET_BASE   = 12'h904;
    localparam logic [11:0] OFF_RAM_CLR_BASE   = 12'h908;
    localparam logic [11:0] RAM_STRIDE         = 12'h010;
    localparam int          RAM_BLOCKS         = 8;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam int          WARN_EN_BIT        = 0;
    localparam int          WARN_LEVEL_LSB     = 1;
    localparam int          WARN_LEVEL_W       = 4;
    localparam logic [3:0]  LEVEL_2V6          = 4'hd;
    localparam logic [3:0]  LEVEL_2V7          = 4'he;
    localparam logic [3:0]  LEVEL_2V8          = 4'hf;
    localparam int          SCRATCH_W          = 8;
    localparam int          SECT_POWER_LSB     = 0;
    localparam int          SECT_RET_LSB       = 16;
    localparam int          SECTIONS           = 2;
    localparam logic [31:0] RAM_CTRL_MASK      = 32'h0003_0003;
    localparam logic [31:0] RAM_CTRL_RESET     = 32'h0000_ffff;
    localparam logic [31:0] ZERO_WORD          = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       enable;
        logic [3:0] level;
    } warn_cfg_s;

    typedef struct packed {
        logic [1:0] retention;
        logic [1:0] power;
    } ram_sect_s;

endpackage

/* rtl/pwr_ret_regs.sv */
// Power and retention register bank behind an Avalon-MM slave.
// Assumes SYS_CLK at 250 MHz, synchronous bus, RST asynchronous active high.
// Operation
// - Warning level codes 13, 14, 15 select 2.6, 2.7, 2.8 volt thresholds.
// - Scratch A at 0x51C holds eight retained bits, reset zero.
// - Register at 0x578 enables the switching regulator.
// - Eight RAM section control registers at 0x900 + n*0x10, only if fitted.
// - Reading the set register at 0x904 + n*0x10 returns the control register.
// - Writing 1 to a set power bit turns that section on in system on.
// - Writing 1 to a set retention bit enables retention while section is off.
//
// The Avalon-MM slave port was decided locally.
module pwr_ret_regs
    import pwr_ret_pkg::*;
#(
    parameter logic [RAM_BLOCKS-1:0] RAM_FITTED = 8'hff
) (
    input  wire logic        SYS_CLK,       // System clock, 250 MHz
    input  wire logic        RST,           // Asynchronous reset, active high
    input  wire logic [11:0] ADDRESS,       // Byte address
    input  wire logic        READ,          // Read request
    input  wire logic        WRITE,         // Write request
    input  wire logic [3:0]  BYTEENABLE,    // Write byte lanes
    input  wire logic [31:0] WRITEDATA,     // Write data
    output logic      [31:0] READDATA,      // Read data, registered
    output logic             WAITREQUEST,   // Stall, low on the accept cycle
    output logic             WARN_ENABLE,   // Supply-drop warning enabled
    output logic      [3:0]  WARN_LEVEL,    // Threshold code
    output logic      [7:0]  SCRATCH_A,     // Retained scratch A
    output logic      [7:0]  SCRATCH_B,     // Retained scratch B
    output logic             REG_ENABLE,    // Switching regulator enable
    output logic      [15:0] SECT_POWER,    // Section power, two bits per block
    output logic      [15:0] SECT_RETAIN    // Section retention, two bits per block
);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait cycle per access gives read data a full clock to settle
    // from the decoder; the access is taken when ack_q is high.
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        req;
    logic        rd_load;
    logic        wr_take;

    assign req         = READ | WRITE;
    assign WAITREQUEST = req & ~ack_q;
    assign rd_load     = READ & ~ack_q;
    assign wr_take     = WRITE & ack_q;

    always_comb begin
        ack_d = req & ~ack_q;
    end

    // Byte-lane merge of write data onto an old value.
    function automatic logic [31:0] merge(input logic [31:0] old_v);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (BYTEENABLE[b]) begin
                r[b*8 +: 8] = WRITEDATA[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] wmask;
    always_comb begin
        wmask = ZERO_WORD;
        for (int b = 0; b < 4; b++) begin
            if (BYTEENABLE[b]) begin
                wmask[b*8 +: 8] = 8'hff;
            end
        end
    end

    // ------------------------------------------------------------
    // Common registers
    // ------------------------------------------------------------
    warn_cfg_s   warn_q;
    warn_cfg_s   warn_d;
    logic [7:0]  scr_a_q;
    logic [7:0]  scr_a_d;
    logic [7:0]  scr_b_q;
    logic [7:0]  scr_b_d;
    logic        regen_q;
    logic        regen_d;
    logic [31:0] m;

    always_comb begin
        warn_d  = warn_q;
        scr_a_d = scr_a_q;
        scr_b_d = scr_b_q;
        regen_d = regen_q;
        m       = ZERO_WORD;
        if (wr_take) begin
            case (ADDRESS)
                OFF_SUPPLY_WARNING: begin
                    m = merge({27'h0, warn_q.level, warn_q.enable});
                    warn_d.enable = m[WARN_EN_BIT];
                    warn_d.level  = m[WARN_LEVEL_LSB +: WARN_LEVEL_W];
                end
                OFF_SCRATCH_A: begin
                    m = merge({24'h000000, scr_a_q});
                    scr_a_d = m[SCRATCH_W-1:0];
                end
                OFF_SCRATCH_B: begin
                    m = merge({24'h000000, scr_b_q});
                    scr_b_d = m[SCRATCH_W-1:0];
                end
                OFF_REG_ENABLE: begin
                    m = merge({31'h0, regen_q});
                    regen_d = m[0];
                end
                default: begin
                    m = ZERO_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ack_q   <= 1'b0;
            warn_q  <= '0;
            scr_a_q <= 8'h00;
            scr_b_q <= 8'h00;
            regen_q <= 1'b0;
        end else begin
            ack_q   <= ack_d;
            warn_q  <= warn_d;
            scr_a_q <= scr_a_d;
            scr_b_q <= scr_b_d;
            regen_q <= regen_d;
        end
    end

    // ------------------------------------------------------------
    // RAM block section control, one per block
    // ------------------------------------------------------------
    logic [31:0] ram_rd [RAM_BLOCKS];
    logic [RAM_BLOCKS-1:0] ram_hit;

    for (genvar n = 0; n < RAM_BLOCKS; n++) begin : g_ram
        localparam logic [11:0] CTRL = OFF_RAM_CTRL_BASE + 12'(n) * RAM_STRIDE;
        localparam logic [11:0] SETA = OFF_RAM_SET_BASE + 12'(n) * RAM_STRIDE;
        localparam logic [11:0] CLRA = OFF_RAM_CLR_BASE + 12'(n) * RAM_STRIDE;
        if (RAM_FITTED[n]) begin : g_fit
            logic [31:0] ctrl_q;
            logic [31:0] ctrl_d;
            always_comb begin
                ctrl_d = ctrl_q;
                if (wr_take) begin
                    if (ADDRESS == CTRL) begin
                        ctrl_d = merge(ctrl_q) & RAM_CTRL_MASK;
                    end else if (ADDRESS == SETA) begin
                        // Only ones set; zeros keep the stored bit
                        ctrl_d = ctrl_q | (WRITEDATA & wmask & RAM_CTRL_MASK);
                    end else if (ADDRESS == CLRA) begin
                        ctrl_d = ctrl_q & ~(WRITEDATA & wmask & RAM_CTRL_MASK);
                    end
                end
            end
            always_ff @(posedge SYS_CLK or posedge RST) begin
                if (RST) begin
                    ctrl_q <= RAM_CTRL_RESET & RAM_CTRL_MASK;
                end else begin
                    ctrl_q <= ctrl_d;
                end
            end
            // Control, set and clear views all read the same value
            assign ram_hit[n] = (ADDRESS == CTRL) | (ADDRESS == SETA) | (ADDRESS == CLRA);
            assign ram_rd[n]  = ctrl_q;
            assign SECT_POWER[2*n +: 2]  = ctrl_q[SECT_POWER_LSB +: SECTIONS];
            assign SECT_RETAIN[2*n +: 2] = ctrl_q[SECT_RET_LSB +: SECTIONS];
        end else begin : g_absent
            // Absent blocks decode as unmapped and keep their section off.
            assign ram_hit[n] = 1'b0;
            assign ram_rd[n]  = ZERO_WORD;
            assign SECT_POWER[2*n +: 2]  = 2'h0;
            assign SECT_RETAIN[2*n +: 2] = 2'h0;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (rd_load) begin
            case (ADDRESS)
                OFF_SUPPLY_WARNING: rdata_d = {27'h0, warn_q.level, warn_q.enable};
                OFF_SCRATCH_A:      rdata_d = {24'h000000, scr_a_q};
                OFF_SCRATCH_B:      rdata_d = {24'h000000, scr_b_q};
                OFF_REG_ENABLE:     rdata_d = {31'h0, regen_q};
                default: begin
                    rdata_d = UNMAPPED_READ;
                    for (int k = 0; k < RAM_BLOCKS; k++) begin
                        if (ram_hit[k]) begin
                            rdata_d = ram_rd[k];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= ZERO_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Read data is loaded at the end of the wait cycle, so it comes from a
    // flop and stands through the accept cycle; no write can slip between.
    assign READDATA = rdata_q;

    assign WARN_ENABLE = warn_q.enable;
    assign WARN_LEVEL  = warn_q.level;
    assign SCRATCH_A   = scr_a_q;
    assign SCRATCH_B   = scr_b_q;
    assign REG_ENABLE  = regen_q;

endmodule

/* dv/pwr_ret_monitor.sv */
// Concurrent checks on the power and retention register bank ports.
// Assumes a bind onto pwr_ret_regs with one clock and async reset.
module pwr_ret_monitor
    import pwr_ret_pkg::*;
(
    input wire logic        SYS_CLK,     // Clock
    input wire logic        RST,         // Reset
    input wire logic [11:0] ADDRESS,     // Address
    input wire logic        READ,        // Read
    input wire logic        WRITE,       // Write
    input wire logic [3:0]  BYTEENABLE,  // Lanes
    input wire logic [31:0] WRITEDATA,   // Write data
    input wire logic [31:0] READDATA,    // Read data
    input wire logic        WAITREQUEST, // Stall
    input wire logic [3:0]  WARN_LEVEL,  // Threshold code
    input wire logic [7:0]  SCRATCH_A,   // Scratch A
    input wire logic        REG_ENABLE,  // Regulator enable
    input wire logic [15:0] SECT_POWER,  // Section power
    input wire logic [15:0] SECT_RETAIN  // Section retention
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wr_ok;
    assign wr_ok = WRITE & ~WAITREQUEST;
    default clocking dc @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    one_wait_a: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
        else $error("Wait state longer than one cycle");
    warn_level_a: assert property (wr_ok && ADDRESS == OFF_SUPPLY_WARNING && BYTEENABLE[0]
        |=> WARN_LEVEL == $past(WRITEDATA[4:1])) else $error("Threshold code not taken");
    scratch_write_a: assert property (wr_ok && ADDRESS == OFF_SCRATCH_A && BYTEENABLE[0]
        |=> SCRATCH_A == $past(WRITEDATA[7:0])) else $error("Scratch write lost");
    scratch_hold_a: assert property (!(wr_ok && ADDRESS == OFF_SCRATCH_A)
        |=> $stable(SCRATCH_A)) else $error("Scratch changed without write");
    regulator_write_a: assert property (wr_ok && ADDRESS == OFF_REG_ENABLE && BYTEENABLE[0]
        |=> REG_ENABLE == $past(WRITEDATA[0])) else $error("Regulator enable not taken");
    set_power_a: assert property (wr_ok && ADDRESS == OFF_RAM_SET_BASE && BYTEENABLE[0]
        |=> SECT_POWER[1:0] == ($past(SECT_POWER[1:0]) | $past(WRITEDATA[1:0])))
        else $error("Power set wrong");
    set_retain_a: assert property (wr_ok && ADDRESS == OFF_RAM_SET_BASE && BYTEENABLE[2]
        |=> SECT_RETAIN[1:0] == ($past(SECT_RETAIN[1:0]) | $past(WRITEDATA[17:16])))
        else $error("Retention set wrong");
    set_read_a: assert property (READ && !WAITREQUEST && ADDRESS == OFF_RAM_SET_BASE
        |-> READDATA == {14'h0, SECT_RETAIN[1:0], 14'h0, SECT_POWER[1:0]})
        else $error("Set register read mismatch");
endmodule

bind pwr_ret_regs pwr_ret_monitor mon (
    .SYS_CLK(SYS_CLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .WARN_LEVEL(WARN_LEVEL), .SCRATCH_A(SCRATCH_A),
    .REG_ENABLE(REG_ENABLE), .SECT_POWER(SECT_POWER), .SECT_RETAIN(SECT_RETAIN)
);

/* dv/pwr_ret_regs_tb.sv */
// Self-checking bench for the power and retention register bank.
// Assumes block 7 is built as absent so the unfitted path is reached.
module pwr_ret_regs_tb
    import pwr_ret_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, rst = 1, read = 0, write = 0, reg_enable, warn_enable;
    logic [11:0] address = 12'h000;
    logic [3:0]  byteenable = 4'hf, warn_level;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic waitrequest;
    logic [7:0]  scratch_a, scratch_b;
    logic [15:0] sect_power;
    int error_cnt = 0, comparisons = 0, cycles = 0;

    pwr_ret_regs #(.RAM_FITTED(8'h7f)) uut (
        .SYS_CLK(sys_clk), .RST(rst), .ADDRESS(address), .READ(read), .WRITE(write),
        .BYTEENABLE(byteenable), .WRITEDATA(writedata), .READDATA(readdata),
        .WAITREQUEST(waitrequest), .WARN_ENABLE(warn_enable), .WARN_LEVEL(warn_level),
        .SCRATCH_A(scratch_a), .SCRATCH_B(scratch_b), .REG_ENABLE(reg_enable),
        .SECT_POWER(sect_power), .SECT_RETAIN()
    );

    always #2 sys_clk = ~sys_clk;

    // Hang guard: far above the roughly 110 cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic final_report();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Called just after a rising edge; holds the request until the edge at
    // which waitrequest is low, then releases and lets one edge pass.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic test_reset();
        bus(0, OFF_SCRATCH_A, 0); chk(q, 32'h0);
        bus(0, OFF_RAM_CTRL_BASE, 0); chk(q, 32'h0000_0003);
    endtask

    task automatic test_warn();
        for (int lv = 13; lv <= 15; lv++) begin
            bus(1, OFF_SUPPLY_WARNING, {27'h0, lv[3:0], 1'b1});
            bus(0, OFF_SUPPLY_WARNING, 0); chk(q, {27'h0, lv[3:0], 1'b1});
            chk({28'h0, warn_level}, lv);
            chk({31'h0, warn_enable}, 32'h1);
        end
    endtask

    task automatic test_scratch_regulator();
        bus(1, OFF_SCRATCH_A, 32'hffff_ffa5);
        bus(0, OFF_SCRATCH_A, 0); chk(q, 32'h0000_00a5);
        chk({24'h0, scratch_a}, 32'h0000_00a5);
        byteenable <= 4'he;
        bus(1, OFF_SCRATCH_A, 32'h0000_0011);
        byteenable <= 4'hf;
        chk({24'h0, scratch_a}, 32'h0000_00a5);
        bus(1, OFF_SCRATCH_B, 32'h0000_005a);
        bus(0, OFF_SCRATCH_B, 0); chk(q, 32'h0000_005a);
        chk({24'h0, scratch_b}, 32'h0000_005a);
        bus(1, OFF_REG_ENABLE, 32'h1); chk({31'h0, reg_enable}, 32'h1);
        bus(1, OFF_REG_ENABLE, 32'h0); chk({31'h0, reg_enable}, 32'h0);
    endtask

    task automatic test_ram_set();
        bus(1, OFF_RAM_CLR_BASE, 32'h0003_0003);
        bus(1, OFF_RAM_SET_BASE, 32'h0001_0001);
        bus(0, OFF_RAM_CTRL_BASE, 0); chk(q, 32'h0001_0001);
        bus(1, OFF_RAM_SET_BASE, 32'h0); // Zeros must not clear anything
        bus(0, OFF_RAM_SET_BASE, 0); chk(q, 32'h0001_0001);
        chk({30'h0, sect_power[1:0]}, 32'h1);
        bus(1, OFF_RAM_SET_BASE, 32'h0002_0002);
        bus(0, OFF_RAM_SET_BASE, 0); chk(q, 32'h0003_0003);
        // Only lane 0 enabled: the retention bits in lane 2 must survive
        byteenable <= 4'h1;
        bus(1, OFF_RAM_CLR_BASE, 32'h0003_0003);
        byteenable <= 4'hf;
        bus(0, OFF_RAM_CTRL_BASE, 0); chk(q, 32'h0003_0000);
    endtask

    task automatic test_absent();
        bus(1, 12'h974, 32'h0003_0003);
        bus(0, 12'h970, 0); chk(q, 32'h0);
        bus(0, 12'h910, 0); chk(q, 32'h0000_0003);
        bus(0, 12'h000, 0); chk(q, 32'h0);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        test_reset();
        test_warn();
        test_scratch_regulator();
        test_ram_set();
        test_absent();
        final_report();
    end
endmodule
